/* rtl/bpc_pkg.sv */
// Package: register map, field positions and reset values of the comparator block
package bpc_pkg;
    // Register byte addresses
    localparam logic [7:0] OFF_CMP_A_EXT = 8'h00;
    localparam logic [7:0] OFF_CMP_A_HI  = 8'h04;
    localparam logic [7:0] OFF_CMP_A_LO  = 8'h08;
    localparam logic [7:0] OFF_CMP_B_EXT = 8'h0C;
    localparam logic [7:0] OFF_CMP_B_HI  = 8'h10;
    localparam logic [7:0] OFF_CMP_B_LO  = 8'h14;
    localparam logic [7:0] OFF_CTRL      = 8'h18;
    localparam logic [7:0] OFF_STATUS    = 8'h1C;
    // Control register fields
    localparam int CTRL_TRACE_EN_BIT  = 0;
    localparam int CTRL_LEGACY_EN_BIT = 1;
    localparam int CTRL_FULL_BIT      = 2;
    localparam int CTRL_A_MASK_LO_BIT = 4;
    localparam int CTRL_A_MASK_HI_BIT = 5;
    localparam int CTRL_B_MASK_LO_BIT = 6;
    localparam int CTRL_B_MASK_HI_BIT = 7;
    // Status register fields
    localparam int STAT_MATCH_A_BIT = 0;
    localparam int STAT_MATCH_B_BIT = 1;
    localparam int STAT_LEGACY_BIT  = 2;
    localparam int STAT_TRACE_BIT   = 3;
    // Extension register fields
    localparam int EXT_SEL_LO_BIT = 6;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // Mode encoding
    typedef enum logic [2:0] {
        BPC_MODE_OFF    = 3'b001,
        BPC_MODE_LEGACY = 3'b010,
        BPC_MODE_TRACE  = 3'b100
    } bpc_mode_t;
endpackage : bpc_pkg

/* rtl/bpc_mode_sel.sv */
// Operating mode selection from the enable bits and secure state
`timescale 1ns/1ps
module bpc_mode_sel
    import bpc_pkg::*;
(
    input  wire logic      legacy_breakpoint_enable,
    input  wire logic      trace_debug_enable,
    input  wire logic      secure_mode,
    output bpc_pkg::bpc_mode_t mode
);
    // Legacy enable overrides; secure mode blocks trace mode
    assign mode = legacy_breakpoint_enable ? BPC_MODE_LEGACY :
                  (trace_debug_enable && !secure_mode) ? BPC_MODE_TRACE :
                  BPC_MODE_OFF;
endmodule : bpc_mode_sel

/* rtl/bpc_addr_cmp.sv */
// One address comparator with mask and page handling
`timescale 1ns/1ps
module bpc_addr_cmp
    import bpc_pkg::*;
(
    input  wire logic [7:0]  ext_reg,
    input  wire logic [7:0]  hi_reg,
    input  wire logic [7:0]  lo_reg,
    input  wire logic        mask_hi,
    input  wire logic        mask_lo,
    input  wire logic        legacy,
    input  wire logic        flash_access,
    input  wire logic [15:0] core_address_bus,
    input  wire logic [21:14] expanded_address_bus,
    output wire logic        hit
);
    // Upper selector bit ignored; bit 6 picks paging outside legacy mode, flash_access picks it in legacy mode
    wire       sel_paged  = ext_reg[EXT_SEL_LO_BIT];
    wire       paged      = legacy ? flash_access : sel_paged;
    // Six page bits compared against the page window in use
    wire [5:0] ext_target = legacy ? {expanded_address_bus[19:14]}
                                   : expanded_address_bus[21:16];
    wire [7:0] hi_target  = (paged && !legacy) ? {expanded_address_bus[15:14],
                                                  core_address_bus[13:8]}
                                               : core_address_bus[15:8];
    // Legacy paged access compares only six high bits
    wire [7:0] hi_care    = (paged && legacy) ? 8'h3F : 8'hFF;
    // Mask decode: x:0 full, 0:1 ignore low, 1:1 ignore both
    wire       use_lo     = !mask_lo;
    wire       use_hi     = !(mask_hi && mask_lo);
    wire       ext_ok     = !paged || (ext_reg[5:0] == ext_target);
    wire       hi_ok      = !use_hi || (((hi_reg ^ hi_target) & hi_care) == 8'h00);
    wire       lo_ok      = !use_lo || (lo_reg == core_address_bus[7:0]);
    assign hit = ext_ok && hi_ok && lo_ok;
endmodule : bpc_addr_cmp

/* rtl/bpc_comparators.sv */
// Comparators A and B with APB register access
`timescale 1ns/1ps
module bpc_comparators
    import bpc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        secure_mode,
    input  wire logic        flash_access,
    input  wire logic [15:0] core_address_bus,
    input  wire logic [21:14] expanded_address_bus,
    input  wire logic [15:0] core_data_bus,
    output logic             match_a,
    output logic             match_b,
    output logic             legacy_breakpoint_mode,
    output logic             trace_debug_mode
);
    import bpc_pkg::*;

    logic [7:0] cmp_a_ext_r;
    logic [7:0] cmp_a_hi_r;
    logic [7:0] cmp_a_lo_r;
    logic [7:0] cmp_b_ext_r;
    logic [7:0] cmp_b_hi_r;
    logic [7:0] cmp_b_lo_r;
    logic [7:0] ctrl_r;
    bpc_mode_t  mode;

    // One register selected for a write in the access phase
    function automatic logic reg_we(input logic       en,
                                    input logic [7:0] a,
                                    input logic [7:0] off);
        reg_we = en && (a == off);
    endfunction : reg_we

    // Byte compare that a mask bit may switch off
    function automatic logic byte_ok(input logic       skip,
                                     input logic [7:0] want,
                                     input logic [7:0] seen);
        byte_ok = skip || (want == seen);
    endfunction : byte_ok

    // Bus decode
    wire setup_phase = psel && !penable;
    wire wr_en       = psel && penable && pwrite;
    wire known       = (paddr[1:0] == 2'b00) && (paddr <= OFF_STATUS);
    wire [7:0] wb    = pwdata[7:0];

    wire full_mode   = ctrl_r[CTRL_FULL_BIT];
    wire a_mask_hi   = ctrl_r[CTRL_A_MASK_HI_BIT];
    wire a_mask_lo   = ctrl_r[CTRL_A_MASK_LO_BIT];
    wire b_mask_hi   = ctrl_r[CTRL_B_MASK_HI_BIT];
    wire b_mask_lo   = ctrl_r[CTRL_B_MASK_LO_BIT];
    wire is_legacy   = (mode == BPC_MODE_LEGACY);
    wire is_trace    = (mode == BPC_MODE_TRACE);
    wire active      = is_legacy || is_trace;

    bpc_mode_sel u_mode (
        .legacy_breakpoint_enable (ctrl_r[CTRL_LEGACY_EN_BIT]),
        .trace_debug_enable       (ctrl_r[CTRL_TRACE_EN_BIT]),
        .secure_mode              (secure_mode),
        .mode                     (mode)
    );

    wire hit_a;
    wire hit_b_addr;

    bpc_addr_cmp u_cmp_a (
        .ext_reg              (cmp_a_ext_r),
        .hi_reg               (cmp_a_hi_r),
        .lo_reg               (cmp_a_lo_r),
        .mask_hi              (a_mask_hi),
        .mask_lo              (a_mask_lo),
        .legacy               (is_legacy),
        .flash_access         (flash_access),
        .core_address_bus     (core_address_bus),
        .expanded_address_bus (expanded_address_bus),
        .hit                  (hit_a)
    );

    bpc_addr_cmp u_cmp_b (
        .ext_reg              (cmp_b_ext_r),
        .hi_reg               (cmp_b_hi_r),
        .lo_reg               (cmp_b_lo_r),
        .mask_hi              (b_mask_hi),
        .mask_lo              (b_mask_lo),
        .legacy               (is_legacy),
        .flash_access         (flash_access),
        .core_address_bus     (core_address_bus),
        .expanded_address_bus (expanded_address_bus),
        .hit                  (hit_b_addr)
    );

    // Full mode data compare: byte masks, no extension compare
    wire data_hi_ok = byte_ok(b_mask_hi, cmp_b_hi_r, core_data_bus[15:8]);
    wire data_lo_ok = byte_ok(b_mask_lo, cmp_b_lo_r, core_data_bus[7:0]);
    wire hit_b_data = data_hi_ok && data_lo_ok;
    wire hit_b      = full_mode ? hit_b_data : hit_b_addr;

    // Read mux
    logic [7:0] rd_byte;
    always_comb
    begin
        case (paddr)
            OFF_CMP_A_EXT: rd_byte = cmp_a_ext_r;
            OFF_CMP_A_HI:  rd_byte = cmp_a_hi_r;
            OFF_CMP_A_LO:  rd_byte = cmp_a_lo_r;
            OFF_CMP_B_EXT: rd_byte = cmp_b_ext_r;
            OFF_CMP_B_HI:  rd_byte = cmp_b_hi_r;
            OFF_CMP_B_LO:  rd_byte = cmp_b_lo_r;
            OFF_CTRL:      rd_byte = ctrl_r;
            OFF_STATUS:    rd_byte = {4'h0, is_trace, is_legacy, match_b, match_a};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Register write enables and next values
    wire       we_a_ext      = reg_we(wr_en, paddr, OFF_CMP_A_EXT);
    wire       we_a_hi       = reg_we(wr_en, paddr, OFF_CMP_A_HI);
    wire       we_a_lo       = reg_we(wr_en, paddr, OFF_CMP_A_LO);
    wire       we_b_ext      = reg_we(wr_en, paddr, OFF_CMP_B_EXT);
    wire       we_b_hi       = reg_we(wr_en, paddr, OFF_CMP_B_HI);
    wire       we_b_lo       = reg_we(wr_en, paddr, OFF_CMP_B_LO);
    wire       we_ctrl       = reg_we(wr_en, paddr, OFF_CTRL);
    wire [7:0] cmp_a_ext_nxt = we_a_ext ? wb : cmp_a_ext_r;
    wire [7:0] cmp_a_hi_nxt  = we_a_hi  ? wb : cmp_a_hi_r;
    wire [7:0] cmp_a_lo_nxt  = we_a_lo  ? wb : cmp_a_lo_r;
    wire [7:0] cmp_b_ext_nxt = we_b_ext ? wb : cmp_b_ext_r;
    wire [7:0] cmp_b_hi_nxt  = we_b_hi  ? wb : cmp_b_hi_r;
    wire [7:0] cmp_b_lo_nxt  = we_b_lo  ? wb : cmp_b_lo_r;
    wire [7:0] ctrl_nxt      = we_ctrl  ? wb : ctrl_r;

    // Comparator A extension register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_a_ext_r <= RST_REG;
        end
        else
        begin
            cmp_a_ext_r <= cmp_a_ext_nxt;
        end
    end

    // Comparator A high register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_a_hi_r <= RST_REG;
        end
        else
        begin
            cmp_a_hi_r <= cmp_a_hi_nxt;
        end
    end

    // Comparator A low register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_a_lo_r <= RST_REG;
        end
        else
        begin
            cmp_a_lo_r <= cmp_a_lo_nxt;
        end
    end

    // Comparator B extension register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_b_ext_r <= RST_REG;
        end
        else
        begin
            cmp_b_ext_r <= cmp_b_ext_nxt;
        end
    end

    // Comparator B high register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_b_hi_r <= RST_REG;
        end
        else
        begin
            cmp_b_hi_r <= cmp_b_hi_nxt;
        end
    end

    // Comparator B low register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_b_lo_r <= RST_REG;
        end
        else
        begin
            cmp_b_lo_r <= cmp_b_lo_nxt;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= RST_REG;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // APB answer: ready one cycle after setup, no wait states
    wire        pready_nxt  = setup_phase;
    wire        pslverr_nxt = setup_phase && !known;
    wire [31:0] prdata_nxt  = setup_phase ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata  <= prdata_nxt;
        end
    end

    // Match outputs registered each bus cycle, silent with no mode active
    wire match_a_nxt = active && hit_a;
    wire match_b_nxt = active && hit_b;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_a <= 1'b0;
            match_b <= 1'b0;
        end
        else
        begin
            match_a <= match_a_nxt;
            match_b <= match_b_nxt;
        end
    end

    // Mode flags registered each cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            legacy_breakpoint_mode <= 1'b0;
            trace_debug_mode       <= 1'b0;
        end
        else
        begin
            legacy_breakpoint_mode <= is_legacy;
            trace_debug_mode       <= is_trace;
        end
    end
endmodule : bpc_comparators

/* bench/bpc_checker.sv */
// Port-level assertions for the breakpoint comparator block
`timescale 1ns/1ps
module bpc_checker
    import bpc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        secure_mode,
    input wire logic        flash_access,
    input wire logic [15:0] core_address_bus,
    input wire logic        match_a,
    input wire logic        match_b,
    input wire logic        legacy_breakpoint_mode,
    input wire logic        trace_debug_mode
);
    logic [7:0] hi_sh_r;
    logic [7:0] lo_sh_r;
    logic [7:0] ctl_sh_r;
    wire logic  wr_ok = psel && penable && pwrite && pready && !pslverr;
    // Expected comparator A hit for a plain legacy access
    wire logic  exp_a = (ctl_sh_r[5] && ctl_sh_r[4]) || (hi_sh_r == core_address_bus[15:8]
                        && (ctl_sh_r[4] || lo_sh_r == core_address_bus[7:0]));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hi_sh_r  <= RST_REG;
            lo_sh_r  <= RST_REG;
            ctl_sh_r <= RST_REG;
        end
        else if (wr_ok && paddr == OFF_CMP_A_HI)
            hi_sh_r <= pwdata[7:0];
        else if (wr_ok && paddr == OFF_CMP_A_LO)
            lo_sh_r <= pwdata[7:0];
        else if (wr_ok && paddr == OFF_CTRL)
            ctl_sh_r <= pwdata[7:0];
    end
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_plain_legacy;
        legacy_breakpoint_mode && $stable(ctl_sh_r) ##1
        legacy_breakpoint_mode && !flash_access && $stable(ctl_sh_r);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero when idle");
    a_unmapped_error: assert property ((s_setup and (paddr > OFF_STATUS)) |=> pslverr)
        else $error("no error for unmapped address");
    a_legacy_wins_trace: assert property (legacy_breakpoint_mode |-> !trace_debug_mode)
        else $error("both modes active");
    a_secure_no_trace: assert property (secure_mode |=> !trace_debug_mode)
        else $error("trace mode while secure");
    a_legacy_from_ctrl: assert property (ctl_sh_r[1] |-> ##[0:2] legacy_breakpoint_mode)
        else $error("legacy mode not entered");
    a_no_mode_match: assert property ((!legacy_breakpoint_mode && !trace_debug_mode) [*2]
        |-> !match_a && !match_b)
        else $error("match without mode");
    a_match_a_plain: assert property (s_plain_legacy |=> match_a == $past(exp_a))
        else $error("comparator A hit wrong");
endmodule : bpc_checker

bind bpc_comparators bpc_checker u_bpc_checker (.*);

/* bench/bpc_cpu_bus.sv */
// CPU core bus model: address, page, data and flash qualifier
`timescale 1ns/1ps
module bpc_cpu_bus
(
    input  wire logic    pclk,
    output logic         flash_access = 1'b0,
    output logic [15:0]  core_address_bus = 16'h0000,
    output logic [21:14] expanded_address_bus = 8'h00,
    output logic [15:0]  core_data_bus = 16'h0000
);
    // One bus cycle, then the inverse so the driven value does not linger on the bus
    task automatic cycle(input logic f, input logic [15:0] a, input logic [7:0] x,
                         input logic [15:0] d);
        @(posedge pclk);
        flash_access         <= f;
        core_address_bus     <= a;
        expanded_address_bus <= x;
        core_data_bus        <= d;
        @(posedge pclk);
        flash_access         <= !f;
        core_address_bus     <= ~a;
        expanded_address_bus <= ~x;
        core_data_bus        <= ~d;
    endtask : cycle
endmodule : bpc_cpu_bus

/* bench/test_breakpoint_address_data_comparators.sv */
// Testbench for the breakpoint comparator block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_breakpoint_address_data_comparators;
    import bpc_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic         secure_mode = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata, rd_data;
    logic         pready, pslverr, rd_err, match_a, match_b, flash_access;
    logic         legacy_breakpoint_mode, trace_debug_mode;
    logic [15:0]  core_address_bus, core_data_bus;
    logic [21:14] expanded_address_bus;
    int           fail_count = 0, total_checks = 0, cyc_count = 0;
    bpc_comparators u_bpc_comparators (.*);
    bpc_cpu_bus u_bpc_cpu_bus (.*);
    always #20 pclk = ~pclk;
    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    always @(posedge pclk)
    begin
        cyc_count++;
        if (cyc_count == 4000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        apb(1'b0, a, 8'h00);
        `CHK("rdata", e, rd_data)
        `CHK("slverr", err, rd_err)
    endtask : rd
    task automatic mode_chk(input logic [7:0] c, input logic s, input logic [1:0] e);
        secure_mode <= s;
        apb(1'b1, OFF_CTRL, c);
        apb(1'b0, OFF_STATUS, 8'h00);
        `CHK("modes", e, {legacy_breakpoint_mode, trace_debug_mode})
        `CHK("status", {e[0], e[1]}, rd_data[3:2])
    endtask : mode_chk
    task automatic run(input logic [7:0] c, x, input logic f, input logic [15:0] a,
                       input logic [7:0] xa, input logic [15:0] d, input logic [1:0] e);
        apb(1'b1, OFF_CTRL, c);
        apb(1'b1, OFF_CMP_A_EXT, x);
        apb(1'b1, OFF_CMP_B_EXT, c[CTRL_FULL_BIT] ? (x ^ 8'h3F) : x);
        u_bpc_cpu_bus.cycle(f, a, xa, d);
        #1;
        `CHK("matches", e, {match_a, match_b})
    endtask : run
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(8'(i * 4), 32'h0000_0000, i == 8);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'(i * 4), 8'hA5 ^ 8'(i));
            rd(8'(i * 4), {24'h00_0000, 8'hA5 ^ 8'(i)}, 1'b0);
        end
        apb(1'b1, OFF_STATUS, 8'hFF);
        rd(OFF_STATUS, 32'h0000_0000, 1'b0);
        apb(1'b1, OFF_CMP_A_HI, 8'h9A);
        apb(1'b1, OFF_CMP_B_HI, 8'h9A);
        apb(1'b1, OFF_CMP_A_LO, 8'h3C);
        apb(1'b1, OFF_CMP_B_LO, 8'h3C);
        mode_chk(8'h03, 1'b0, 2'b10);
        mode_chk(8'h01, 1'b0, 2'b01);
        mode_chk(8'h01, 1'b1, 2'b00);
        mode_chk(8'h02, 1'b1, 2'b10);
        mode_chk(8'h00, 1'b0, 2'b00);
        run(8'h02, 8'h05, 0, 16'h9A3C, 8'h00, 16'h0000, 2'b11);
        run(8'h02, 8'h05, 0, 16'h9A3D, 8'h00, 16'h0000, 2'b00);
        run(8'h02, 8'h05, 1, 16'h5A3C, 8'hC5, 16'h0000, 2'b11);
        run(8'h02, 8'h05, 1, 16'h5A3C, 8'hC6, 16'h0000, 2'b00);
        run(8'h52, 8'h05, 0, 16'h9A77, 8'h00, 16'h0000, 2'b11);
        run(8'hF2, 8'h05, 1, 16'h1234, 8'h05, 16'h0000, 2'b11);
        run(8'hF2, 8'h05, 1, 16'h1234, 8'h06, 16'h0000, 2'b00);
        run(8'hA2, 8'h05, 0, 16'h9A77, 8'h00, 16'h0000, 2'b00);
        run(8'h01, 8'h05, 0, 16'h9A3C, 8'hFF, 16'h0000, 2'b11);
        run(8'h01, 8'h45, 0, 16'h1A3C, 8'h16, 16'h0000, 2'b11);
        run(8'h01, 8'hC5, 0, 16'h1A3C, 8'h16, 16'h0000, 2'b11);
        run(8'h01, 8'h85, 0, 16'h9A3C, 8'hFF, 16'h0000, 2'b11);
        run(8'h01, 8'h45, 0, 16'h1A3C, 8'h15, 16'h0000, 2'b00);
        run(8'h06, 8'h05, 1, 16'h9A3C, 8'h05, 16'h9A3C, 2'b11);
        run(8'h06, 8'h05, 1, 16'h9A3C, 8'h05, 16'h9A3D, 2'b10);
        run(8'h46, 8'h05, 1, 16'h9A3C, 8'h05, 16'h9AFF, 2'b11);
        run(8'h86, 8'h05, 1, 16'h9A3C, 8'h05, 16'hFF3C, 2'b11);
        run(8'h86, 8'h05, 1, 16'h9A3C, 8'h05, 16'h9A3D, 2'b10);
        print_verdict();
    end
endmodule : test_breakpoint_address_data_comparators
